// ### src/fault_seq_pkg.sv
package fault_seq_pkg;
  // clock and derived timing counts
  localparam int CLK_HZ = 10_000_000;
  localparam int PULSE_US = 200;
  localparam int SS_TIMEOUT_MS = 16;
  localparam int RESTART_MS = 160;
  localparam int PULSE_CYC = (CLK_HZ / 1_000_000) * PULSE_US;
  localparam int SS_CYC = (CLK_HZ / 1000) * SS_TIMEOUT_MS;
  localparam int RESTART_CYC = (CLK_HZ / 1000) * RESTART_MS;
  localparam int TMR_W = 21;
  // deglitch defaults, durations are free choices
  localparam int UV_DG = 64;
  localparam int OV_DG = 32;
  localparam int OT_DG = 128;
  localparam int DG_W = 16;
  // cycles the own pin sink is masked from enable after release
  localparam int HOLD_CYC = 6;
  localparam int SSM_DIV = 4;
  localparam int SSM_W = 4;
  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // status and mask bit positions
  localparam int EV_UV = 0;
  localparam int EV_OV = 1;
  localparam int EV_OT = 2;
  localparam int EV_TMO = 3;
  localparam int EV_LOCK = 4;
  localparam int EV_RESTART = 5;
  localparam int NUM_EV = 6;
  localparam logic [NUM_EV-1:0] MASK_RST = 6'h00;
  localparam int CTRL_DIS = 0;
  // state register fields
  localparam int STF_SET = 8;
  localparam int STF_SW = 12;
  localparam int STF_SINK = 13;
  // output setpoint codes
  localparam logic [1:0] SET_OFF = 2'h0;
  localparam logic [1:0] SET_5V0 = 2'h1;
  localparam logic [1:0] SET_5V5 = 2'h2;
  // synchronised input indices
  localparam int IN_EN = 0;
  localparam int IN_SEL = 1;
  localparam int IN_UV = 2;
  localparam int IN_OV = 3;
  localparam int IN_PT = 4;
  localparam int IN_STH = 5;
  localparam int IN_IUV = 6;
  localparam int IN_IOV = 7;
  localparam int IN_REG = 8;
  localparam int IN_VUP = 9;
  localparam int IN_BURST = 10;
  localparam int N_IN = 11;
  // deglitch channel indices
  localparam int DG_UV = 0;
  localparam int DG_OV = 1;
  localparam int DG_OT = 2;
  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_SOFT = 7'h02,
    ST_REG = 7'h04,
    ST_DGL = 7'h08,
    ST_PULSE = 7'h10,
    ST_WAIT = 7'h20,
    ST_LOCK = 7'h40
  } seq_state_e;
endpackage : fault_seq_pkg

// ### src/converter_fault_restart_sequencer.sv
`timescale 1ns/100ps
module converter_fault_restart_sequencer
  import fault_seq_pkg::*;
#(
  parameter int unsigned RESTART_CYCLES = RESTART_CYC,
  parameter int unsigned SS_TIMEOUT_CYCLES = SS_CYC,
  parameter int unsigned UV_DEGLITCH_CYCLES = UV_DG,
  parameter int unsigned OV_DEGLITCH_CYCLES = OV_DG,
  parameter int unsigned OT_DEGLITCH_CYCLES = OT_DG
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic enable_fault_pin_in,
  output logic enable_fault_pin_out,
  output logic enable_fault_pin_oe,
  input wire logic select_pin,
  input wire logic output_below_uv,
  input wire logic output_above_ov,
  input wire logic primary_thermal_trip,
  input wire logic secondary_thermal_trip,
  input wire logic input_undervoltage,
  input wire logic input_overvoltage,
  input wire logic output_in_regulation,
  input wire logic output_above_uvlo,
  input wire logic burst_start,
  output logic switching_on,
  output logic duty_limit,
  output logic power_limit,
  output logic overvoltage_clamp,
  output logic [1:0] setpoint,
  output logic [SSM_W-1:0] ssm_code,
  output logic enable_pulldown_on,
  output logic select_pulldown_on,
  output logic irq
);

  localparam int unsigned DG_LIM [3] =
    '{UV_DEGLITCH_CYCLES, OV_DEGLITCH_CYCLES, OT_DEGLITCH_CYCLES};

  logic [N_IN-1:0] pin_vec, s1_q, s2_q, s3_q, pin_q;
  seq_state_e state_q, state_d;
  logic [TMR_W-1:0] timer_q;
  logic [DG_W-1:0] dg_q [3];
  logic [2:0] flt, dg_act, dg_hit;
  logic lockout, act, ign, en_hold_q, en_eff, lock_ov_q, sink_d, sink_q;
  logic [3:0] hold_q;
  logic burst_q, soft_dis_q;
  logic [1:0] div_q;
  logic up_q;
  logic [NUM_EV-1:0] status_q, mask_q, ev, clr;
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wen_q;
  logic wlane_q;
  logic [1:0] bresp_q;

  // register index decode, shared by read and write
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_STATUS: reg_sel = 3'h0;
      OFS_MASK: reg_sel = 3'h1;
      OFS_STATE: reg_sel = 3'h2;
      OFS_CTRL: reg_sel = 3'h3;
      default: reg_sel = 3'h4;
    endcase
  endfunction : reg_sel

  assign pin_vec = {burst_start, output_above_uvlo, output_in_regulation,
    input_overvoltage, input_undervoltage, secondary_thermal_trip,
    primary_thermal_trip, output_above_ov, output_below_uv, select_pin,
    enable_fault_pin_in};

  // three-stage sync; a change counts when stages two and three agree
  // pulled-down pins settle low
  for (genvar i = 0; i < N_IN; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        s3_q[i] <= 1'b0;
        pin_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pin_vec[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) pin_q[i] <= s3_q[i];
      end
    end
  end

  assign enable_pulldown_on = 1'b1;
  assign select_pulldown_on = 1'b1;

  assign flt[DG_UV] = pin_q[IN_UV];
  assign flt[DG_OV] = pin_q[IN_OV];
  assign flt[DG_OT] = pin_q[IN_PT] | pin_q[IN_STH];
  assign lockout = pin_q[IN_IUV] | pin_q[IN_IOV];
  assign act = state_q inside {ST_SOFT, ST_REG, ST_DGL};

  // one deglitch counter per fault kind
  // undervoltage is normal while ramping, so soft-start skips it
  for (genvar k = 0; k < 3; k++) begin : g_dgl
    assign dg_act[k] = flt[k] && (state_q inside {ST_REG, ST_DGL} ||
      (state_q == ST_SOFT && k != DG_UV));
    assign dg_hit[k] = dg_act[k] && dg_q[k] == DG_W'(DG_LIM[k] - 1);
    always_ff @(posedge aclk) begin
      if (!aresetn) dg_q[k] <= '0;
      else if (!dg_act[k]) dg_q[k] <= '0;
      else if (!dg_hit[k]) dg_q[k] <= dg_q[k] + 1'b1;
    end
  end

  // own sink pulls the pin low; mask enable meanwhile, keep last level
  assign ign = sink_q || hold_q != 4'h0 || state_q == ST_PULSE;
  assign en_eff = (ign ? en_hold_q : pin_q[IN_EN]) && !soft_dis_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_hold_q <= 1'b0;
      hold_q <= 4'h0;
    end else begin
      if (!ign) en_hold_q <= pin_q[IN_EN];
      if (sink_q) hold_q <= 4'(HOLD_CYC);
      else if (hold_q != 4'h0) hold_q <= hold_q - 4'h1;
    end
  end

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (!lockout) state_d = ST_SOFT;
      end
      ST_SOFT, ST_REG, ST_DGL: begin
        if (lockout) state_d = ST_LOCK;
        else if (dg_hit[DG_OT] || dg_hit[DG_UV]) state_d = ST_PULSE;
        // overvoltage: no pulse, straight to retry wait
        else if (dg_hit[DG_OV]) state_d = ST_WAIT;
        else if (state_q == ST_SOFT &&
                 timer_q == TMR_W'(SS_TIMEOUT_CYCLES - 1))
          state_d = ST_PULSE;
        else if (state_q == ST_SOFT && pin_q[IN_REG]) state_d = ST_REG;
        else if (state_q == ST_REG && |flt) state_d = ST_DGL;
        else if (state_q == ST_DGL && !(|flt)) state_d = ST_REG;
      end
      ST_PULSE: begin
        if (timer_q == TMR_W'(PULSE_CYC - 1)) state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (timer_q == TMR_W'(RESTART_CYCLES - 1)) state_d = ST_SOFT;
      end
      // resume at once when lockout clears; after input overvoltage, not before the sink pulse ends
      ST_LOCK: begin
        if (!lockout && (!lock_ov_q || timer_q >= TMR_W'(PULSE_CYC - 1)))
          state_d = ST_SOFT;
      end
      default: state_d = ST_OFF;
    endcase
    if (!en_eff) state_d = ST_OFF;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) state_q <= ST_OFF;
    else state_q <= state_d;
  end

  // shared timer restarts on every state change
  // pulse and wait only run down, faults cannot reload them
  always_ff @(posedge aclk) begin
    if (!aresetn) timer_q <= '0;
    else if (state_d != state_q) timer_q <= '0;
    else if (timer_q != '1) timer_q <= timer_q + 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) lock_ov_q <= 1'b0;
    else if (state_q != ST_LOCK && state_d == ST_LOCK)
      lock_ov_q <= pin_q[IN_IOV];
  end

  // sink on fault shutdown except output overvoltage and input undervoltage, input overvoltage included
  assign sink_d = state_q == ST_PULSE || (state_q == ST_LOCK &&
    lock_ov_q && timer_q < TMR_W'(PULSE_CYC));

  // power stage controls, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sink_q <= 1'b0;
      switching_on <= 1'b0;
      duty_limit <= 1'b0;
      power_limit <= 1'b0;
      overvoltage_clamp <= 1'b0;
    end else begin
      sink_q <= sink_d;
      switching_on <= act;
      // duty limit in soft-start until the output is above UVLO, and while deglitching
      duty_limit <= (state_q == ST_SOFT && !pin_q[IN_VUP]) ||
        state_q == ST_DGL;
      power_limit <= state_q == ST_DGL && flt[DG_UV];
      overvoltage_clamp <= flt[DG_OV];
    end
  end

  assign enable_fault_pin_out = 1'b0;
  assign enable_fault_pin_oe = sink_q;

  // select sampled only below the 2.7V point of soft-start
  always_ff @(posedge aclk) begin
    if (!aresetn) setpoint <= SET_OFF;
    else if (state_q == ST_OFF) setpoint <= SET_OFF;
    else if (state_q == ST_SOFT && !pin_q[IN_VUP])
      setpoint <= pin_q[IN_SEL] ? SET_5V0 : SET_5V5;
  end

  // triangle sweep restarted at each burst, full span in 60 cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burst_q <= 1'b0;
      div_q <= 2'h0;
      up_q <= 1'b1;
      ssm_code <= '0;
    end else begin
      burst_q <= pin_q[IN_BURST];
      if (pin_q[IN_BURST] && !burst_q) begin
        div_q <= 2'h0;
        up_q <= 1'b1;
        ssm_code <= '0;
      end else begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'(SSM_DIV - 1)) begin
          if (up_q && ssm_code == '1) up_q <= 1'b0;
          else if (!up_q && ssm_code == '0) up_q <= 1'b1;
          else if (up_q) ssm_code <= ssm_code + 1'b1;
          else ssm_code <= ssm_code - 1'b1;
        end
      end
    end
  end

  // events into sticky status
  always_comb begin
    ev = '0;
    ev[EV_UV] = act && state_d == ST_PULSE && dg_hit[DG_UV];
    ev[EV_OT] = act && state_d == ST_PULSE && dg_hit[DG_OT];
    ev[EV_OV] = act && state_d == ST_WAIT;
    ev[EV_TMO] = state_q == ST_SOFT && state_d == ST_PULSE &&
      !dg_hit[DG_UV] && !dg_hit[DG_OT];
    ev[EV_LOCK] = state_q != ST_LOCK && state_d == ST_LOCK;
    ev[EV_RESTART] = state_q == ST_WAIT && state_d == ST_SOFT;
  end

  // write-one-to-clear; a same-cycle event wins over the clear
  assign clr = (wen_q && reg_sel(awaddr_q) == 3'h0) ?
    wbyte_q[NUM_EV-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
      mask_q <= MASK_RST;
      soft_dis_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      status_q <= (status_q & ~clr) | ev;
      irq <= |(((status_q & ~clr) | ev) & mask_q);
      if (wen_q && reg_sel(awaddr_q) == 3'h1)
        mask_q <= wbyte_q[NUM_EV-1:0];
      if (wen_q && reg_sel(awaddr_q) == 3'h3)
        soft_dis_q <= wbyte_q[CTRL_DIS];
    end
  end

  // write channel: address and data taken in any order
  assign awready = !aw_full_q && !bvalid_q;
  assign wready = !w_full_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      wen_q <= 1'b0;
    end else begin
      wen_q <= 1'b0;
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        wbyte_q <= wdata[7:0];
        // strobe may move once data is taken, so keep it with the data
        wlane_q <= wstrb[0];
      end
      // upper lanes hold only zeros, so only lane 0 is checked
      if (aw_full_q && w_full_q) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        wen_q <= reg_sel(awaddr_q) != 3'h4 && wlane_q;
        bresp_q <= reg_sel(awaddr_q) == 3'h4 ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid_q && bready) bvalid_q <= 1'b0;
    end
  end

  // read channel: one cycle to data, unmapped reads zero with error
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
      case (reg_sel(araddr))
        3'h0: rdata[NUM_EV-1:0] <= status_q;
        3'h1: rdata[NUM_EV-1:0] <= mask_q;
        3'h2: begin
          rdata[6:0] <= state_q;
          rdata[STF_SET+1:STF_SET] <= setpoint;
          rdata[STF_SW] <= switching_on;
          rdata[STF_SINK] <= sink_q;
        end
        3'h3: rdata[CTRL_DIS] <= soft_dis_q;
        default: rresp <= RESP_SLVERR;
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // helper: length of the last sink pulse
  logic [TMR_W-1:0] sink_len_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) sink_len_q <= '0;
    else if (!sink_q) sink_len_q <= '0;
    else sink_len_q <= sink_len_q + 1'b1;
  end

  a_pulse_length: assert property (
    $fell(sink_q) && $past(state_q, 2) == ST_PULSE |->
      $past(sink_len_q) == TMR_W'(PULSE_CYC - 1))
    else $error("fault pulse length wrong");
  a_pulse_then_wait: assert property (
    state_q == ST_PULSE && timer_q == TMR_W'(PULSE_CYC - 1) && en_eff
      |=> state_q == ST_WAIT && !sink_d)
    else $error("restart wait not started after pulse");
  a_wait_to_soft: assert property (
    state_q == ST_WAIT && timer_q == TMR_W'(RESTART_CYCLES - 1) && en_eff
      |=> state_q == ST_SOFT ##1 switching_on)
    else $error("no soft-start after restart wait");
  a_dgl_limit: assert property (
    state_q == ST_DGL |=> duty_limit)
    else $error("duty limit missing while deglitching");
  a_power_limit: assert property (
    state_q == ST_DGL && flt[DG_UV] && $stable(flt) |=> power_limit)
    else $error("power limit missing on undervoltage");
  a_sink_cause: assert property (
    $rose(sink_q) |-> $past(state_q) inside {ST_PULSE, ST_LOCK})
    else $error("sink without fault shutdown");
  a_lock_resume: assert property (
    state_q == ST_LOCK && !lockout && !lock_ov_q && en_eff
      |=> state_q == ST_SOFT)
    else $error("lockout release not immediate");
  a_ss_timeout: assert property (
    state_q == ST_SOFT && timer_q == TMR_W'(SS_TIMEOUT_CYCLES - 1) &&
      en_eff && !lockout |=> state_q inside {ST_PULSE, ST_WAIT})
    else $error("soft-start timeout ignored");
  a_no_retrigger: assert property (
    state_q == ST_WAIT && !$past(state_q == ST_WAIT) |->
      timer_q == '0 ##1 (state_q != ST_WAIT || timer_q == TMR_W'(1)))
    else $error("restart wait reloaded");
  a_disable_off: assert property (
    !en_eff |=> state_q == ST_OFF ##1 setpoint == SET_OFF)
    else $error("disable did not stop output");

  c_hiccup: cover property (state_q == ST_WAIT ##1 state_q == ST_SOFT);
  c_regulate: cover property (state_q == ST_SOFT ##1 state_q == ST_REG);
  c_ov_lock: cover property ($rose(sink_q) && state_q == ST_LOCK);
  c_irq: cover property ($rose(irq));

endmodule : converter_fault_restart_sequencer

// ### sim/host_mcu_model.sv
`timescale 1ns/100ps
// host side of the enable/fault pin, timing low pulses
module host_mcu_model (
  input wire logic aclk,
  input wire logic host_en,
  input wire logic use_resistor,
  input wire logic pin_oe,
  output logic pin_level,
  output int pulse_count,
  output int last_pulse_len
);
  int run_len = 0;
  // resistor lets sink win
  // a direct tie hides the sink, so no report reaches the host then
  assign pin_level = (pin_oe && use_resistor) ? 1'h0 : host_en;
  // low while enabled is a fault
  // host always drives a level, the pin is never left open
  always @(posedge aclk) begin
    if (!pin_level && host_en) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_pulse_len <= run_len;
      pulse_count <= pulse_count + 1;
      run_len <= 0;
    end
  end
  initial begin
    pulse_count = 0;
    last_pulse_len = 0;
  end
endmodule : host_mcu_model

// ### sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import fault_seq_pkg::*;
  localparam int R = 300;
  localparam int S = 200;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, setp;
  logic [31:0] rdata, d;
  logic [1:0] r;
  logic host_en = 1'h0, sel = 1'h0, uv = 1'h0, ov = 1'h0;
  logic pt = 1'h0, st = 1'h0, iuv = 1'h0, iov = 1'h0;
  logic reg_ok = 1'h0, uvlo = 1'h0, burst = 1'h0;
  logic pin, pin_out, oe, sw, dl, pl, clamp, epd, spd, irq;
  logic [SSM_W-1:0] spread_spectrum_modulation, mx;
  int pulses, plen, t;
  int cyc = 0;
  int bad_count = 0;
  int compares = 0;

  // 10 MHz clock and a free cycle count for timing
  always #50 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  converter_fault_restart_sequencer #(
    .RESTART_CYCLES(R),
    .SS_TIMEOUT_CYCLES(S)
  ) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .enable_fault_pin_in(pin), .enable_fault_pin_out(pin_out),
    .enable_fault_pin_oe(oe), .select_pin(sel),
    .output_below_uv(uv), .output_above_ov(ov),
    .primary_thermal_trip(pt), .secondary_thermal_trip(st),
    .input_undervoltage(iuv), .input_overvoltage(iov),
    .output_in_regulation(reg_ok), .output_above_uvlo(uvlo),
    .burst_start(burst), .switching_on(sw), .duty_limit(dl),
    .power_limit(pl), .overvoltage_clamp(clamp), .setpoint(setp),
    .ssm_code(spread_spectrum_modulation), .enable_pulldown_on(epd),
    .select_pulldown_on(spd), .irq(irq)
  );

  host_mcu_model i_host (
    .aclk(aclk), .host_en(host_en), .use_resistor(1'h1),
    .pin_oe(oe), .pin_level(pin),
    .pulse_count(pulses), .last_pulse_len(plen)
  );

  task automatic check(input string what, input logic [33:0] seen,
                       input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic inr(input int v, input int lo, input int hi);
    return (v >= lo) && (v <= hi);
  endfunction : inr

  function automatic logic pick(input int w);
    return (w == 0) ? sw : oe;
  endfunction : pick

  // ready and valid are sampled at the falling edge, stable to the next
  // rising edge since everything here moves only on rising edges
  // waits have no own limit, the hang guard ends a stuck transfer
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] rs;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    b_hs = 1'h0;
    rs = 2'h3;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = awvalid && (awready === 1'h1);
      w_hs = wvalid && (wready === 1'h1);
      b_hs = (bvalid === 1'h1);
      rs = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'h0;
      if (w_hs) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    check("write resp", rs, RESP_OKAY);
  endtask : axi_write

  task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] v,
                          output logic [1:0] rs);
    logic ar_hs, r_hs;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    r_hs = 1'h0;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = arvalid && (arready === 1'h1);
      r_hs = (rvalid === 1'h1);
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'h0;
    end
    rready <= 1'h0;
  endtask : axi_read

  // bounded wait on switching (0) or the pin sink (1)
  task automatic wait_for(input int w, input logic lvl, input int lim);
    int n;
    n = 0;
    while (pick(w) !== lvl && n < lim) begin
      @(posedge aclk);
      #1;
      n++;
    end
    check("wait level", pick(w), lvl);
  endtask : wait_for

  task automatic stop_test;
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // hang guard, well beyond the roughly 12000 cycles the tests need
  initial begin
    repeat (40000) @(posedge aclk);
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (8) @(posedge aclk);
    check("pulldowns", {epd, spd}, 2'h3);
    check("sink drive level", pin_out, 1'h0);
    axi_read(OFS_STATE, d, r);
    check("state reset", d, 32'h01);
    axi_read(OFS_MASK, d, r);
    check("mask reset", d, 32'h0);
    axi_read(8'h40, d, r);
    check("unmapped", {r, d}, {RESP_SLVERR, 32'h0});
    axi_write(OFS_MASK, 32'h3F);
    sel <= 1'h1;
    reg_ok <= 1'h1;
    host_en <= 1'h1;
    wait_for(0, 1'h1, 40);
    @(posedge aclk);
    uvlo <= 1'h1;
    repeat (10) @(posedge aclk);
    check("setpoint high sel", setp, SET_5V0);
    // undervoltage hiccup; a thermal trip inside the pulse is ignored
    uv <= 1'h1;
    t = cyc;
    repeat (8) @(posedge aclk);
    #1;
    check("limit modes", {dl, pl}, 2'h3);
    wait_for(1, 1'h1, UV_DG + 30);
    check("uv deglitch", inr(cyc - t, UV_DG, UV_DG + 12), 1'h1);
    check("stopped", sw, 1'h0);
    @(posedge aclk);
    pt <= 1'h1;
    repeat (200) @(posedge aclk);
    pt <= 1'h0;
    wait_for(1, 1'h0, 2100);
    t = cyc;
    axi_read(OFS_STATUS, d, r);
    check("pulse len", plen, PULSE_CYC);
    check("status uv", d, 32'h1 << EV_UV);
    check("irq set", irq, 1'h1);
    axi_write(OFS_STATUS, 32'h3F);
    repeat (3) @(posedge aclk);
    #1;
    check("irq clear", irq, 1'h0);
    wait_for(0, 1'h1, R + 50);
    check("restart gap", inr(cyc - t, R, R + 8), 1'h1);
    wait_for(1, 1'h1, 200);
    @(posedge aclk);
    uv <= 1'h0;
    wait_for(1, 1'h0, 2100);
    wait_for(0, 1'h1, R + 50);
    check("second pulse", pulses, 2);
    repeat (20) @(posedge aclk);
    axi_read(OFS_STATE, d, r);
    check("regulating", d[6:0], 7'h04);
    // secondary thermal trip
    st <= 1'h1;
    t = cyc;
    wait_for(1, 1'h1, OT_DG + 30);
    check("ot deglitch", inr(cyc - t, OT_DG, OT_DG + 12), 1'h1);
    @(posedge aclk);
    st <= 1'h0;
    axi_read(OFS_STATUS, d, r);
    check("status ot", d[EV_OT], 1'h1);
    wait_for(1, 1'h0, 2100);
    wait_for(0, 1'h1, R + 50);
    repeat (20) @(posedge aclk);
    // overvoltage: clamp, no pulse, retry
    ov <= 1'h1;
    repeat (8) @(posedge aclk);
    #1;
    check("clamp", {clamp, dl}, 2'h3);
    wait_for(0, 1'h0, OV_DG + 30);
    t = cyc;
    check("no ov pulse", oe, 1'h0);
    @(posedge aclk);
    ov <= 1'h0;
    wait_for(0, 1'h1, R + 50);
    check("ov retry", inr(cyc - t, R, R + 8), 1'h1);
    // disable, then soft-start timeout with select low
    @(posedge aclk);
    host_en <= 1'h0;
    repeat (10) @(posedge aclk);
    check("disabled", {sw, setp}, {1'h0, SET_OFF});
    sel <= 1'h0;
    reg_ok <= 1'h0;
    uvlo <= 1'h0;
    host_en <= 1'h1;
    wait_for(0, 1'h1, 40);
    t = cyc;
    repeat (10) @(posedge aclk);
    check("setpoint low sel", setp, SET_5V5);
    wait_for(1, 1'h1, S + 50);
    check("ss timeout", inr(cyc - t, S - 2, S + 8), 1'h1);
    @(posedge aclk);
    reg_ok <= 1'h1;
    uvlo <= 1'h1;
    wait_for(1, 1'h0, 2100);
    wait_for(0, 1'h1, R + 50);
    repeat (20) @(posedge aclk);
    // input lockouts resume without the restart wait
    iuv <= 1'h1;
    wait_for(0, 1'h0, 20);
    check("no uvlo pulse", oe, 1'h0);
    @(posedge aclk);
    iuv <= 1'h0;
    wait_for(0, 1'h1, 12);
    @(posedge aclk);
    iov <= 1'h1;
    wait_for(1, 1'h1, 20);
    @(posedge aclk);
    iov <= 1'h0;
    wait_for(1, 1'h0, 2100);
    wait_for(0, 1'h1, 12);
    // one burst must sweep the whole band span
    @(posedge aclk);
    burst <= 1'h1;
    repeat (2) @(posedge aclk);
    burst <= 1'h0;
    repeat (4) @(posedge aclk);
    #1;
    check("sweep restart", spread_spectrum_modulation, 4'h0);
    mx = 4'h0;
    repeat (66) begin
      @(posedge aclk);
      #1;
      if (spread_spectrum_modulation > mx) mx = spread_spectrum_modulation;
    end
    check("sweep top", mx, 4'hF);
    // soft disable through the control register acts as enable low
    axi_write(OFS_CTRL, 32'h1);
    repeat (3) @(posedge aclk);
    #1;
    check("soft disable", sw, 1'h0);
    axi_read(OFS_CTRL, d, r);
    check("ctrl readback", {r, d}, {RESP_OKAY, 32'h1});
    axi_write(OFS_CTRL, 32'h0);
    wait_for(0, 1'h1, 40);
    stop_test();
  end
endmodule : tb_top
